// >>> hw/adcch_pkg.sv
// adcch_pkg: register map, field layout and types of one converter channel.
// assumes a 32-bit apb slave, one register per aligned word, byte address = 4 * index.
package adcch_pkg;
   localparam int ADDR_W = 6;
   localparam int IDX_W = 4;
   // register indexes
   localparam logic [IDX_W-1:0] IDX_CTRL = 4'h0;
   localparam logic [IDX_W-1:0] IDX_INPUT_SEL = 4'h1;
   localparam logic [IDX_W-1:0] IDX_IRQ_CTRL = 4'h2;
   localparam logic [IDX_W-1:0] IDX_IRQ_FLAG = 4'h3;
   localparam logic [IDX_W-1:0] IDX_RESULT_LOW = 4'h4;
   localparam logic [IDX_W-1:0] IDX_RESULT_HIGH = 4'h5;
   localparam logic [IDX_W-1:0] IDX_CONFIG = 4'h8;
   localparam logic [IDX_W-1:0] IDX_THRESHOLD = 4'h9;
   localparam logic [IDX_W-1:0] IDX_ROUTE_STAT = 4'hA;
   // writable masks, reserved bits stay zero
   localparam logic [7:0] MASK_CTRL = 8'h03;
   localparam logic [7:0] MASK_INPUT_SEL = 8'h7F;
   localparam logic [7:0] MASK_IRQ_CTRL = 8'h0F;
   localparam logic [7:0] MASK_CONFIG = 8'h07;
   // field positions
   localparam int POS_LSB = 3;
   localparam int NEG_LSB = 0;
   localparam int COND_LSB = 2;
   localparam int LVL_LSB = 0;
   localparam int FLAG_BIT = 0;
   localparam int CFG_SIGNED_BIT = 0;
   localparam int CFG_RES_LSB = 1;
   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [15:0] RST_THRESHOLD = 16'h0000;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      ADCCH_KIND_INTERNAL = 2'b00,
      ADCCH_KIND_SINGLE = 2'b01,
      ADCCH_KIND_TWO_PIN = 2'b10,
      ADCCH_KIND_TWO_PIN_AMP = 2'b11
   } adcch_kind_e;

   typedef enum logic [1:0] {
      ADCCH_COND_COMPLETE = 2'b00,
      ADCCH_COND_BELOW = 2'b01,
      ADCCH_COND_RSVD = 2'b10,
      ADCCH_COND_ABOVE = 2'b11
   } adcch_cond_e;

   typedef enum logic [1:0] {
      ADCCH_RES_12_RIGHT = 2'b00,
      ADCCH_RES_8 = 2'b01,
      ADCCH_RES_12_LEFT = 2'b10,
      ADCCH_RES_RSVD = 2'b11
   } adcch_res_e;

   typedef enum logic [1:0] {
      ADCCH_NEG_PIN = 2'b00,
      ADCCH_NEG_PAD_GND = 2'b01,
      ADCCH_NEG_INNER_GND = 2'b11,
      ADCCH_NEG_NONE = 2'b10
   } adcch_neg_e;

   localparam logic [3:0] INT_TEMP = 4'b0000;
   localparam logic [3:0] INT_BANDGAP = 4'b0001;
   localparam logic [3:0] INT_SUPPLY_TENTH = 4'b0010;

   typedef struct packed {
      logic valid;
      logic pos_internal;
      logic [3:0] pos_index;
      logic neg_used;
      adcch_neg_e neg_kind;
      logic [2:0] neg_pin;
      logic gain_en;
   } adcch_route_s;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } adcch_apb_req_s;
endpackage : adcch_pkg

// >>> hw/adcch_channel.sv
// adcch_channel: one converter channel, input routing, compare flag, result pair.
// assumes a 25 MHz apb clock; converter result and vector ack arrive on that clock.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module adcch_channel #(
   parameter int CONV_W = 12
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [adcch_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   input wire logic i_conv_done,
   input wire logic [CONV_W-1:0] i_conv_data,
   input wire logic i_vector_ack,
   output adcch_pkg::adcch_route_s o_route,
   output logic o_irq_req,
   output logic [1:0] o_irq_level
);
   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic rst_meta_ff;
   logic rst_b_ff;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_b_ff <= rst_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [7:0] input_sel_ff, nxt_input_sel;
   logic [7:0] irq_ctrl_ff, nxt_irq_ctrl;
   logic [7:0] config_ff, nxt_config;
   logic [15:0] threshold_ff, nxt_threshold;
   logic flag_ff, nxt_flag;
   logic [15:0] result_ff, nxt_result;
   logic [7:0] high_temp_ff, nxt_high_temp;
   logic [31:0] prdata_ff, nxt_prdata;
   logic slverr_ff, nxt_slverr;

   adcch_pkg::adcch_apb_req_s req;
   logic setup;
   logic wr_acc;
   logic [adcch_pkg::IDX_W-1:0] idx;
   logic mapped;
   logic [7:0] wbyte;

   assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                  paddr: i_paddr, pwdata: i_pwdata};
   assign setup = req.psel && !req.penable;
   assign wr_acc = req.psel && req.penable && req.pwrite;
   assign idx = req.paddr[adcch_pkg::ADDR_W-1:2];
   assign wbyte = req.pwdata[7:0];

   always_comb begin
      case (idx)
         adcch_pkg::IDX_CTRL, adcch_pkg::IDX_INPUT_SEL, adcch_pkg::IDX_IRQ_CTRL,
         adcch_pkg::IDX_IRQ_FLAG, adcch_pkg::IDX_RESULT_LOW,
         adcch_pkg::IDX_RESULT_HIGH, adcch_pkg::IDX_CONFIG,
         adcch_pkg::IDX_THRESHOLD, adcch_pkg::IDX_ROUTE_STAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration fields
   adcch_pkg::adcch_kind_e kind;
   adcch_pkg::adcch_cond_e cond;
   adcch_pkg::adcch_res_e res_mode;
   logic signed_mode;
   logic [3:0] pos_sel;
   logic [2:0] neg_sel;
   logic [1:0] level;

   assign kind = adcch_pkg::adcch_kind_e'(ctrl_ff[1:0]);
   assign pos_sel = input_sel_ff[adcch_pkg::POS_LSB +: 4];
   assign neg_sel = input_sel_ff[adcch_pkg::NEG_LSB +: 3];
   assign cond = adcch_pkg::adcch_cond_e'(irq_ctrl_ff[adcch_pkg::COND_LSB +: 2]);
   assign level = irq_ctrl_ff[adcch_pkg::LVL_LSB +: 2];
   assign signed_mode = config_ff[adcch_pkg::CFG_SIGNED_BIT];
   assign res_mode = adcch_pkg::adcch_res_e'(config_ff[adcch_pkg::CFG_RES_LSB +: 2]);

   ////////////////////////////////////////////////////////////////////////////
   // input routing
   adcch_pkg::adcch_route_s route;
   logic two_pin;

   assign two_pin = signed_mode && kind[1];

   always_comb begin
      route = '{valid: 1'b0, pos_internal: 1'b0, pos_index: pos_sel, neg_used: 1'b0,
                neg_kind: adcch_pkg::ADCCH_NEG_NONE, neg_pin: 3'b000, gain_en: 1'b0};
      case (kind)
         adcch_pkg::ADCCH_KIND_INTERNAL: begin
            route.pos_internal = 1'b1;
            route.valid = (pos_sel == adcch_pkg::INT_TEMP) ||
                          (pos_sel == adcch_pkg::INT_BANDGAP) ||
                          (pos_sel == adcch_pkg::INT_SUPPLY_TENTH);
         end
         adcch_pkg::ADCCH_KIND_SINGLE: route.valid = 1'b1;
         adcch_pkg::ADCCH_KIND_TWO_PIN: begin
            route.neg_used = 1'b1;
            route.valid = signed_mode;
            case (neg_sel)
               3'b101: route.neg_kind = adcch_pkg::ADCCH_NEG_PAD_GND;
               3'b111: route.neg_kind = adcch_pkg::ADCCH_NEG_INNER_GND;
               3'b100, 3'b110: route.valid = 1'b0;
               default: begin
                  route.neg_kind = adcch_pkg::ADCCH_NEG_PIN;
                  route.neg_pin = neg_sel;
               end
            endcase
         end
         default: begin
            route.neg_used = 1'b1;
            route.gain_en = 1'b1;
            route.valid = signed_mode && !pos_sel[3];
            case (neg_sel)
               3'b100: route.neg_kind = adcch_pkg::ADCCH_NEG_INNER_GND;
               3'b111: route.neg_kind = adcch_pkg::ADCCH_NEG_PAD_GND;
               3'b101, 3'b110: route.valid = 1'b0;
               default: begin
                  route.neg_kind = adcch_pkg::ADCCH_NEG_PIN;
                  route.neg_pin = {1'b1, neg_sel[1:0]};
               end
            endcase
         end
      endcase
      if (!two_pin) begin
         route.neg_used = 1'b0;
         route.neg_kind = adcch_pkg::ADCCH_NEG_NONE;
         route.neg_pin = 3'b000;
         route.gain_en = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result formatting and compare
   logic [15:0] fmt_result;
   logic meets;
   logic below;
   logic above;

   always_comb begin
      case (res_mode)
         adcch_pkg::ADCCH_RES_8: begin
            fmt_result = {{8{signed_mode && i_conv_data[7]}}, i_conv_data[7:0]};
         end
         adcch_pkg::ADCCH_RES_12_LEFT: begin
            fmt_result = {i_conv_data[11:4], i_conv_data[3:0], 4'h0};
         end
         default: begin
            fmt_result = {{4{two_pin && i_conv_data[11]}}, i_conv_data[11:0]};
         end
      endcase
      if (signed_mode) begin
         below = $signed(fmt_result) < $signed(threshold_ff);
         above = $signed(fmt_result) > $signed(threshold_ff);
      end else begin
         below = fmt_result < threshold_ff;
         above = fmt_result > threshold_ff;
      end
      case (cond)
         adcch_pkg::ADCCH_COND_COMPLETE: meets = 1'b1;
         adcch_pkg::ADCCH_COND_BELOW: meets = below;
         adcch_pkg::ADCCH_COND_ABOVE: meets = above;
         default: meets = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // register next state
   logic flag_set;
   logic flag_clr;

   assign flag_set = i_conv_done && meets;
   assign flag_clr = i_vector_ack ||
                     (wr_acc && idx == adcch_pkg::IDX_IRQ_FLAG &&
                      wbyte[adcch_pkg::FLAG_BIT]);

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_input_sel = input_sel_ff;
      nxt_irq_ctrl = irq_ctrl_ff;
      nxt_config = config_ff;
      nxt_threshold = threshold_ff;
      nxt_result = i_conv_done ? fmt_result : result_ff;
      nxt_high_temp = high_temp_ff;
      nxt_flag = flag_set ? 1'b1 : (flag_clr ? 1'b0 : flag_ff);
      if (wr_acc) begin
         case (idx)
            adcch_pkg::IDX_CTRL: nxt_ctrl = wbyte & adcch_pkg::MASK_CTRL;
            adcch_pkg::IDX_INPUT_SEL: nxt_input_sel = wbyte & adcch_pkg::MASK_INPUT_SEL;
            adcch_pkg::IDX_IRQ_CTRL: nxt_irq_ctrl = wbyte & adcch_pkg::MASK_IRQ_CTRL;
            adcch_pkg::IDX_CONFIG: nxt_config = wbyte & adcch_pkg::MASK_CONFIG;
            adcch_pkg::IDX_THRESHOLD: nxt_threshold = req.pwdata[15:0];
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
      // low byte read latches high byte for a 16-bit pair, coherent unless a conversion ends in the read's setup cycle
      if (req.psel && req.penable && !req.pwrite && idx == adcch_pkg::IDX_RESULT_LOW) begin
         nxt_high_temp = result_ff[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, prepared in the setup cycle
   always_comb begin
      nxt_prdata = prdata_ff;
      nxt_slverr = 1'b0;
      if (setup) begin
         nxt_slverr = !mapped;
         case (idx)
            adcch_pkg::IDX_CTRL: nxt_prdata = {24'h00_0000, ctrl_ff};
            adcch_pkg::IDX_INPUT_SEL: nxt_prdata = {24'h00_0000, input_sel_ff};
            adcch_pkg::IDX_IRQ_CTRL: nxt_prdata = {24'h00_0000, irq_ctrl_ff};
            adcch_pkg::IDX_IRQ_FLAG: nxt_prdata = {31'h0000_0000, flag_ff};
            adcch_pkg::IDX_RESULT_LOW: nxt_prdata = {24'h00_0000, result_ff[7:0]};
            adcch_pkg::IDX_RESULT_HIGH: nxt_prdata = {24'h00_0000, high_temp_ff};
            adcch_pkg::IDX_CONFIG: nxt_prdata = {24'h00_0000, config_ff};
            adcch_pkg::IDX_THRESHOLD: nxt_prdata = {16'h0000, threshold_ff};
            adcch_pkg::IDX_ROUTE_STAT: nxt_prdata = {19'h0_0000, route};
            default: nxt_prdata = adcch_pkg::RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         ctrl_ff <= adcch_pkg::RST_REG8;
         input_sel_ff <= adcch_pkg::RST_REG8;
         irq_ctrl_ff <= adcch_pkg::RST_REG8;
         config_ff <= adcch_pkg::RST_REG8;
         threshold_ff <= adcch_pkg::RST_THRESHOLD;
         flag_ff <= 1'b0;
         result_ff <= adcch_pkg::RST_THRESHOLD;
         high_temp_ff <= adcch_pkg::RST_REG8;
         prdata_ff <= adcch_pkg::RD_ZERO;
         slverr_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         input_sel_ff <= nxt_input_sel;
         irq_ctrl_ff <= nxt_irq_ctrl;
         config_ff <= nxt_config;
         threshold_ff <= nxt_threshold;
         flag_ff <= nxt_flag;
         result_ff <= nxt_result;
         high_temp_ff <= nxt_high_temp;
         prdata_ff <= nxt_prdata;
         slverr_ff <= nxt_slverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign o_pready = 1'b1;
   assign o_pslverr = slverr_ff && req.psel && req.penable;
   assign o_prdata = prdata_ff;
   assign o_route = route;
   assign o_irq_level = level;
   assign o_irq_req = flag_ff && (level != 2'b00);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   flag_set_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (i_conv_done && cond == adcch_pkg::ADCCH_COND_COMPLETE) |=> flag_ff)
      else $error("flag not set on conversion end");
   cmp_gate_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (!flag_ff && i_conv_done && cond == adcch_pkg::ADCCH_COND_ABOVE && !above)
      |=> !flag_ff)
      else $error("flag set without compare hit");
   cmp_below_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (!flag_ff && i_conv_done && cond == adcch_pkg::ADCCH_COND_BELOW && !below)
      |=> !flag_ff)
      else $error("flag set without below hit");
   cond_rsvd_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (!flag_ff && i_conv_done && cond == adcch_pkg::ADCCH_COND_RSVD) |=> !flag_ff)
      else $error("reserved condition set flag");
   pair_latch_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (req.psel && req.penable && !req.pwrite && idx == adcch_pkg::IDX_RESULT_LOW)
      |=> high_temp_ff == $past(result_ff[15:8]))
      else $error("high byte not latched on low read");
   flag_w1c_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (wr_acc && idx == adcch_pkg::IDX_IRQ_FLAG && wbyte[0] && !i_conv_done) |=> !flag_ff)
      else $error("write one did not clear flag");
   flag_w0_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (flag_ff && wr_acc && idx == adcch_pkg::IDX_IRQ_FLAG && !wbyte[0] && !i_vector_ack)
      |=> flag_ff)
      else $error("write zero cleared flag");
   vec_clear_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (i_vector_ack && !i_conv_done) |=> !flag_ff ##1 (!flag_ff || $past(i_conv_done)))
      else $error("vector did not clear flag");
   irq_raise_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      ($rose(flag_ff) && level != 2'b00) |-> o_irq_req && o_irq_level == level)
      else $error("request missing for set flag");
   irq_off_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (level == 2'b00) |-> !o_irq_req)
      else $error("request with level zero");
   amp_pos_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (kind == adcch_pkg::ADCCH_KIND_TWO_PIN_AMP && pos_sel[3]) |-> !o_route.valid)
      else $error("amplified top code accepted");
   neg_unused_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (!kind[1]) |-> !o_route.neg_used && !o_route.gain_en)
      else $error("negative select used in one pin kind");
   unsigned_rsvd_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (!signed_mode && kind[1]) |-> !o_route.valid)
      else $error("reserved kind accepted unsigned");
   sign_ext_a: assert property (@(posedge i_clk) disable iff (!rst_b_ff)
      (i_conv_done && res_mode == adcch_pkg::ADCCH_RES_12_RIGHT)
      |=> result_ff[15:12] == {4{$past(two_pin) && $past(i_conv_data[11])}})
      else $error("high nibble not sign extended");
endmodule : adcch_channel

// >>> dv/adcch_conv_model.sv
// adcch_conv_model: far-side source and converter, answers a start after a wait.
// assumes start pulses come from the bench one at a time; data churns while idle.
`timescale 1ns/1ns
module adcch_conv_model (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire logic [11:0] i_sample,
   input wire logic [3:0] i_wait,
   output logic o_done,
   output logic [11:0] o_data
);
   logic busy_ff;
   logic [3:0] cnt_ff;
   logic [11:0] held_ff;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_ff <= 1'b0;
         cnt_ff <= 4'h0;
         held_ff <= 12'h000;
         o_done <= 1'b0;
         o_data <= 12'h000;
      end else begin
         o_done <= 1'b0;
         // no stale value outside the done cycle
         o_data <= ~o_data;
         if (i_start) begin
            busy_ff <= 1'b1;
            cnt_ff <= i_wait;
            held_ff <= i_sample;
         end else if (busy_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
         end else if (busy_ff) begin
            busy_ff <= 1'b0;
            o_done <= 1'b1;
            o_data <= held_ff;
         end
      end
   end
endmodule : adcch_conv_model

// >>> dv/adcch_channel_tb.sv
// adcch_channel_tb: register, routing, flag and result checks over apb.
// assumes the zero-wait apb slave and one-cycle flag latency of the channel.
`timescale 1ns/1ns
module adcch_channel_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic cstart = 1'b0;
   logic vack = 1'b0;
   logic [5:0] paddr = 6'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [11:0] csamp = 12'h000;
   logic [3:0] cwait = 4'h0;
   logic pready, pslverr, done, irq;
   logic [1:0] lvl;
   logic [31:0] prdata, rd;
   logic [11:0] cdata;
   logic er;
   adcch_pkg::adcch_route_s route, ex, msk;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   // cfg, kind, threshold, condition, sample, flag
   logic [15:0] cmp_tab [9][6] = '{'{0, 1, 16'h0800, 1, 12'h7FF, 1},
      '{0, 1, 16'h0800, 1, 12'h800, 0}, '{0, 1, 16'h0800, 3, 12'h801, 1},
      '{0, 1, 16'h0800, 3, 12'h800, 0}, '{0, 1, 16'h0800, 2, 12'h7FF, 0},
      '{0, 1, 16'h0800, 2, 12'h801, 0}, '{1, 2, 16'h0000, 1, 12'hFFF, 1},
      '{0, 1, 16'h0000, 1, 12'hFFF, 0}, '{1, 2, 16'h0000, 3, 12'h001, 1}};
   // cfg, kind, sample, low, high
   logic [11:0] fmt_tab [6][5] = '{'{1, 2, 12'hFFF, 8'hFF, 8'hFF},
      '{1, 1, 12'h800, 8'h00, 8'h08}, '{4, 1, 12'hABC, 8'hC0, 8'hAB},
      '{3, 1, 12'h080, 8'h80, 8'hFF}, '{0, 1, 12'hABC, 8'hBC, 8'h0A},
      '{6, 1, 12'hABC, 8'hBC, 8'h0A}};

   always #20 clk = ~clk;

   adcch_channel dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_prdata(prdata), .i_conv_done(done), .i_conv_data(cdata),
      .i_vector_ack(vack), .o_route(route), .o_irq_req(irq), .o_irq_level(lvl));
   adcch_conv_model src_u (.i_clk(clk), .i_rst_b(rst_b), .i_start(cstart),
      .i_sample(csamp), .i_wait(cwait), .o_done(done), .o_data(cdata));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic chk_rd(input logic [3:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rd, exp, "register read");
   endtask : chk_rd

   task automatic conv(input logic [11:0] s, input logic [3:0] w);
      cstart <= 1'b1;
      csamp <= s;
      cwait <= w;
      @(posedge clk);
      cstart <= 1'b0;
      do begin
         @(posedge clk);
      end while (done !== 1'b1);
      @(posedge clk);
   endtask : conv

   function automatic adcch_pkg::adcch_route_s exp_route(input logic s, input logic [1:0] k,
      input logic [3:0] p, input logic [2:0] n, output adcch_pkg::adcch_route_s m);
      adcch_pkg::adcch_route_s r;
      r = '0;
      m = '1;
      r.valid = 1'b1;
      r.pos_index = p;
      r.neg_kind = adcch_pkg::ADCCH_NEG_NONE;
      if (k == 2'b00) begin
         r.pos_internal = 1'b1;
         r.valid = (p <= 4'h2);
      end
      if (k[1]) begin
         r.valid = s & ~(k[0] & p[3]);
         r.neg_used = 1'b1;
         r.gain_en = k[0];
         if (!n[2]) begin
            r.neg_kind = adcch_pkg::ADCCH_NEG_PIN;
            r.neg_pin = {k[0], n[1:0]};
         end else if (n == 3'b111) begin
            r.neg_kind = k[0] ? adcch_pkg::ADCCH_NEG_PAD_GND : adcch_pkg::ADCCH_NEG_INNER_GND;
         end else if (n == {2'b10, ~k[0]}) begin
            r.neg_kind = k[0] ? adcch_pkg::ADCCH_NEG_INNER_GND : adcch_pkg::ADCCH_NEG_PAD_GND;
         end else begin
            r.valid = 1'b0;
         end
         if (r.neg_kind != adcch_pkg::ADCCH_NEG_PIN) m.neg_pin = '0;
      end
      if (!r.valid) begin
         m = '0;
         m.valid = 1'b1;
      end
      return r;
   endfunction : exp_route

   task automatic tally_and_finish();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 1; i < 6; i++) chk_rd(4'(i), 32'h0000_0000);
      apb(1'b1, adcch_pkg::IDX_INPUT_SEL, 32'h0000_00FF);
      chk_rd(adcch_pkg::IDX_INPUT_SEL, 32'h0000_007F);
      apb(1'b1, adcch_pkg::IDX_IRQ_CTRL, 32'h0000_00FF);
      chk_rd(adcch_pkg::IDX_IRQ_CTRL, 32'h0000_000F);
      apb(1'b1, 4'h6, 32'h0000_00FF);
      chk(32'(er), 32'h0000_0001, "unmapped write error");
      chk_rd(4'h6, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001, "unmapped read error");
      // every mode, positive and negative code
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, adcch_pkg::IDX_CONFIG, 32'(s));
         for (int k = 0; k < 4; k++) begin
            apb(1'b1, adcch_pkg::IDX_CTRL, 32'(k));
            for (int p = 0; p < 16; p++) begin
               for (int n = 0; n < 8; n++) begin
                  apb(1'b1, adcch_pkg::IDX_INPUT_SEL, {25'h0, p[3:0], n[2:0]});
                  ex = exp_route(s[0], k[1:0], p[3:0], n[2:0], msk);
                  chk(32'(route & msk), 32'(ex & msk), "route");
               end
            end
         end
      end
      apb(1'b1, adcch_pkg::IDX_INPUT_SEL, 32'h0000_0000);
      apb(1'b1, adcch_pkg::IDX_CONFIG, 32'h0000_0000);
      apb(1'b1, adcch_pkg::IDX_CTRL, 32'h0000_0001);
      chk_rd(adcch_pkg::IDX_ROUTE_STAT, {19'h0_0000, 1'b1, 1'b0, 4'h0, 1'b0,
         adcch_pkg::ADCCH_NEG_NONE, 3'b000, 1'b0});
      apb(1'b1, adcch_pkg::IDX_IRQ_CTRL, 32'h0000_0002);
      conv(12'hABC, 4'h0);
      chk(32'({irq, lvl}), 32'h0000_0006, "request and level");
      chk_rd(adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0001);
      apb(1'b1, adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
      chk_rd(adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0001);
      apb(1'b1, adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0001);
      chk_rd(adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000, "request after clear");
      conv(12'h123, 4'h9);
      chk(32'(irq), 32'h0000_0001, "request before vector");
      vack <= 1'b1;
      @(posedge clk);
      vack <= 1'b0;
      @(posedge clk);
      chk(32'(irq), 32'h0000_0000, "request after vector");
      chk_rd(adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0000);
      apb(1'b1, adcch_pkg::IDX_IRQ_CTRL, 32'h0000_0000);
      conv(12'h001, 4'h2);
      chk(32'(irq), 32'h0000_0000, "request at level zero");
      chk_rd(adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0001);
      apb(1'b1, adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0001);
      // compare conditions, unsigned and signed
      foreach (cmp_tab[i]) begin
         apb(1'b1, adcch_pkg::IDX_CONFIG, 32'(cmp_tab[i][0]));
         apb(1'b1, adcch_pkg::IDX_CTRL, 32'(cmp_tab[i][1]));
         apb(1'b1, adcch_pkg::IDX_THRESHOLD, 32'(cmp_tab[i][2]));
         apb(1'b1, adcch_pkg::IDX_IRQ_CTRL, {28'h0, cmp_tab[i][3][1:0], 2'b01});
         conv(cmp_tab[i][4][11:0], 4'h1);
         chk_rd(adcch_pkg::IDX_IRQ_FLAG, 32'(cmp_tab[i][5]));
         chk(32'(irq), 32'(cmp_tab[i][5]), "compare request");
         apb(1'b1, adcch_pkg::IDX_IRQ_FLAG, 32'h0000_0001);
      end
      // result formats, low byte read first
      apb(1'b1, adcch_pkg::IDX_IRQ_CTRL, 32'h0000_0000);
      foreach (fmt_tab[i]) begin
         apb(1'b1, adcch_pkg::IDX_CONFIG, 32'(fmt_tab[i][0]));
         apb(1'b1, adcch_pkg::IDX_CTRL, 32'(fmt_tab[i][1]));
         conv(fmt_tab[i][2], 4'h3);
         chk_rd(adcch_pkg::IDX_RESULT_LOW, 32'(fmt_tab[i][3]));
         chk_rd(adcch_pkg::IDX_RESULT_HIGH, 32'(fmt_tab[i][4]));
      end
      tally_and_finish();
   end
endmodule : adcch_channel_tb
